// *** inc/hfr_defs.svh ***
// Purpose: constants for the heater fault alarm two and restart mode block
// Assumes: 100 MHz clock, register port with one-cycle read latency
// Notes: offsets are word byte addresses
`ifndef HFR_DEFS_SVH
`define HFR_DEFS_SVH

// register byte addresses
`define HFR_ADDR_CTRL 8'h00
`define HFR_ADDR_DELAY 8'h04
`define HFR_ADDR_RESTART 8'h08
`define HFR_ADDR_STATUS 8'h0C
`define HFR_ADDR_MASK 8'h10
`define HFR_ADDR_STATE 8'h14

// ctrl field positions
`define HFR_CTRL_SEL_LSB 0
`define HFR_CTRL_SEL_MSB 2
`define HFR_CTRL_TYPE_BIT 4

// reset values
`define HFR_SEL_RESET 3'h0
`define HFR_TYPE_RESET 1'h0
`define HFR_DELAY_RESET 8'h05
`define HFR_RESTART_RESET 2'h0

// output selector codes
`define HFR_SEL_NONE 3'h0
`define HFR_SEL_FIRST 3'h1
`define HFR_SEL_SECOND 3'h2

// status bits
`define HFR_ST_ALARM 0
`define HFR_ST_RESTART 1
`define HFR_ST_NBITS 2

// power failure tolerance
`define HFR_PF_MS 20
`define HFR_CLK_MHZ 100

`endif

// *** inc/hfr_pkg.sv ***
// Purpose: types for the heater fault alarm two and restart mode block
// Assumes: nothing
// Notes: constants live in hfr_defs.svh
package hfr_pkg;

  // restart mode selector codes
  typedef enum logic [1:0] {
    HFR_HOT_ONE = 2'h0,
    HFR_HOT_TWO = 2'h1,
    HFR_COLD = 2'h2,
    HFR_STOP = 2'h3
  } hfr_restart_t;

  // source of the control output after recovery
  typedef enum logic [2:0] {
    HFR_OUT_HOLD = 3'h0,
    HFR_OUT_COMPUTE = 3'h1,
    HFR_OUT_LOW_LIMIT = 3'h2,
    HFR_OUT_STOP_VALUE = 3'h3,
    HFR_OUT_NONE = 3'h4,
    HFR_OUT_VALVE = 3'h5
  } hfr_out_src_t;

  // supply supervision states
  typedef enum logic [1:0] {
    HFR_PS_RUN,
    HFR_PS_DIP,
    HFR_PS_DOWN
  } hfr_pwr_state_t;

endpackage

// *** rtl/hfr_delay_filter.sv ***
// Purpose: consecutive-sample filter for the heater fault alarm
// Assumes: sample_i is a one-cycle strobe at the alarm sampling rate
// Notes: a count of zero raises the alarm on the first sample in range
`include "hfr_defs.svh"

module hfr_delay_filter #(
  parameter int CW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sample stream
  input wire logic sample_i,
  input wire logic in_range_i,
  input wire logic enable_i,
  input wire logic [CW-1:0] count_i,
  // filtered alarm
  output logic alarm_o
);

  initial begin
    if (CW < 1 || CW > 16) $error("hfr_delay_filter: CW out of range");
  end

  typedef struct packed {
    logic [CW-1:0] run;
    logic alarm;
  } hfr_filt_t;

  hfr_filt_t s;
  hfr_filt_t next_s;

  // count consecutive in-range samples, clear on any out-of-range one
  always_comb begin
    next_s = s;
    if (!enable_i) begin
      next_s.run = '0;
      next_s.alarm = 1'b0;
    end else if (sample_i) begin
      if (!in_range_i) begin
        next_s.run = '0;
        next_s.alarm = 1'b0;
      end else if (s.run >= count_i) begin
        next_s.alarm = 1'b1;
      end else begin
        next_s.run = s.run + 1'b1;
        next_s.alarm = ((s.run + 1'b1) >= count_i);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign alarm_o = s.alarm;

endmodule // hfr_delay_filter

// *** rtl/hfr_top.sv ***
// Purpose: heater fault alarm two configuration and restart mode decision
// Assumes: register port, single 100 MHz clock, inputs synchronous
// Notes: control computation and current comparison values come from outside
`include "hfr_defs.svh"

// What this block does
// - the sensor-two output selector holds 0 for off, 1 for first output, 2 for second output, 3 to 7 reserved, reset 0.
// - alarm two is bound automatically to whatever output sensor two is assigned to.
// - both sensors may be assigned to the same output without conflict.
// - the alarm two type is 0 for type A and 1 for type B, reset 0.
// - alarm status rises only after the current stays in alarm range for a set count of samples, 0 to 255, reset 5.
// - supply dips of 20 ms or less are ridden through; only longer ones invoke the restart mode.
// - the restart selector codes 0 hot start one, 1 hot start two, 2 cold start, 3 stop start, reset 0.
// - hot start one resumes the previous mode and holds the output near its previous value.
// - hot start two resumes the previous mode: fresh computation in auto, low limit in manual, no motor drive in manual position control without feedback.
// - cold start enters manual at the low limit, and without feedback input in position control drives no motor.
// - stop start enters the stop state whatever ran before and outputs the stop-mode value.
// - in position control without feedback input, stop start drives the valve per the configured stop valve action.
// - after a stop start, going from stop to run restores the mode held before the failure.
// - when startup autotune or auto temperature rise runs at power-on, hot start one becomes hot start two.
// - the alarm delay equals the count times a sampling time of twice the measured-input sampling cycle.
// - type A compares the load current with the set values; type B compares it to a current proportional to the output.
module hfr_top #(
  parameter int DELAY_W = 8,
  parameter int CUR_W = 12,
  parameter int SAMPLE_CYCLES = 10000000,
  parameter int PF_CYCLES = `HFR_PF_MS * 1000 * `HFR_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // current sensor two
  input wire logic [CUR_W-1:0] current_i,
  input wire logic [CUR_W-1:0] break_limit_i,
  input wire logic [CUR_W-1:0] melt_limit_i,
  input wire logic [CUR_W-1:0] manipulated_output_i,
  input wire logic first_output_on_i,
  input wire logic second_output_on_i,
  // supply and run conditions
  input wire logic supply_ok_i,
  input wire logic was_auto_i,
  input wire logic was_run_i,
  input wire logic feedback_resistance_input_i,
  input wire logic position_control_i,
  input wire logic startup_autotune_i,
  input wire logic auto_rise_i,
  input wire logic stop_to_run_i,
  // results
  output logic [1:0] heater_fault_alarm_two_o,
  output logic restart_valid_o,
  output logic restart_auto_o,
  output logic restart_run_o,
  output logic [2:0] out_src_o,
  output logic irq_o
);

  initial begin
    if (DELAY_W < 8 || DELAY_W > 16) begin
      $error("hfr_top: DELAY_W out of range");
    end
    if (CUR_W < 2 || CUR_W > 24) begin
      $error("hfr_top: CUR_W out of range");
    end
    if (SAMPLE_CYCLES < 2 || PF_CYCLES < 2) begin
      $error("hfr_top: cycle counts too small");
    end
  end

  // reset release through two flip-flops
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // selector code is valid only for the two output codes, first and second
  function automatic logic sel_valid(input logic [2:0] code);
    sel_valid = (code == `HFR_SEL_FIRST) || (code == `HFR_SEL_SECOND);
  endfunction

  typedef struct packed {
    logic [2:0] sel;
    logic typ;
    logic [DELAY_W-1:0] delay;
    hfr_pkg::hfr_restart_t restart;
    logic [`HFR_ST_NBITS-1:0] status;
    logic [`HFR_ST_NBITS-1:0] mask;
    logic [31:0] rdata;
    logic [31:0] samp_cnt;
    logic sample;
    logic [31:0] pf_cnt;
    hfr_pkg::hfr_pwr_state_t pwr;
    logic restart_valid;
    logic restart_auto;
    logic restart_run;
    logic pend_restore;
    logic saved_auto;
    hfr_pkg::hfr_out_src_t out_src;
    logic [1:0] hfa;
    logic alarm_q;
    logic irq;
  } hfr_state_t;

  hfr_state_t s;
  hfr_state_t next_s;
  logic alarm_raw;
  logic in_range;
  logic out_on;

  // output that sensor two watches, current output may share with sensor one
  always_comb begin
    case (s.sel)
      `HFR_SEL_FIRST: begin
        out_on = first_output_on_i;
      end
      `HFR_SEL_SECOND: begin
        out_on = second_output_on_i;
      end
      default: begin
        out_on = 1'b0;
      end
    endcase
  end

  // alarm range by type: A against set values, B against output-proportional current
  always_comb begin
    if (!s.typ) begin
      in_range = out_on ? (current_i < break_limit_i) : (current_i > melt_limit_i);
    end else begin
      in_range = (current_i < (manipulated_output_i >> 1));
    end
  end

  hfr_delay_filter #(
    .CW(DELAY_W)
  ) u_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .sample_i(s.sample),
    .in_range_i(in_range),
    .enable_i(sel_valid(s.sel)),
    .count_i(s.delay),
    .alarm_o(alarm_raw)
  );

  // next state
  always_comb begin
    hfr_pkg::hfr_restart_t eff;
    logic [`HFR_ST_NBITS-1:0] ev;
    eff = s.restart;
    ev = '0;
    next_s = s;
    next_s.rdata = '0;
    // register writes
    if (wr_i) begin
      case (addr_i)
        `HFR_ADDR_CTRL: begin
          next_s.sel = wdata_i[`HFR_CTRL_SEL_MSB:`HFR_CTRL_SEL_LSB];
          next_s.typ = wdata_i[`HFR_CTRL_TYPE_BIT];
        end
        `HFR_ADDR_DELAY: begin
          next_s.delay = wdata_i[DELAY_W-1:0];
        end
        `HFR_ADDR_RESTART: begin
          next_s.restart = hfr_pkg::hfr_restart_t'(wdata_i[1:0]);
        end
        `HFR_ADDR_MASK: begin
          next_s.mask = wdata_i[`HFR_ST_NBITS-1:0];
        end
        default: ;
      endcase
    end
    // register reads, one cycle later
    if (rd_i) begin
      case (addr_i)
        `HFR_ADDR_CTRL: begin
          next_s.rdata = {27'h0, s.typ, 1'b0, s.sel};
        end
        `HFR_ADDR_DELAY: begin
          next_s.rdata = 32'(s.delay);
        end
        `HFR_ADDR_RESTART: begin
          next_s.rdata = {30'h0, s.restart};
        end
        `HFR_ADDR_STATUS: begin
          next_s.rdata = 32'(s.status);
        end
        `HFR_ADDR_MASK: begin
          next_s.rdata = 32'(s.mask);
        end
        `HFR_ADDR_STATE: begin
          next_s.rdata = {24'h0, s.restart_valid, s.restart_run, s.restart_auto, s.out_src, s.hfa};
        end
        default: begin
          next_s.rdata = 32'h0;
        end
      endcase
    end
    // sample strobe every two measured-input cycles
    if (s.samp_cnt >= 32'(SAMPLE_CYCLES - 1)) begin
      next_s.samp_cnt = '0;
      next_s.sample = 1'b1;
    end else begin
      next_s.samp_cnt = s.samp_cnt + 32'h1;
      next_s.sample = 1'b0;
    end
    // alarm binds to the assigned output
    next_s.alarm_q = alarm_raw;
    case (s.sel)
      `HFR_SEL_FIRST: begin
        next_s.hfa = {1'b0, alarm_raw};
      end
      `HFR_SEL_SECOND: begin
        next_s.hfa = {alarm_raw, 1'b0};
      end
      default: begin
        next_s.hfa = 2'h0;
      end
    endcase
    if (alarm_raw && !s.alarm_q) begin
      ev[`HFR_ST_ALARM] = 1'b1;
    end
    // supply supervision
    next_s.restart_valid = 1'b0;
    case (s.pwr)
      hfr_pkg::HFR_PS_RUN: begin
        next_s.pf_cnt = '0;
        if (!supply_ok_i) begin
          next_s.pwr = hfr_pkg::HFR_PS_DIP;
        end
      end
      hfr_pkg::HFR_PS_DIP: begin
        if (supply_ok_i) begin
          next_s.pwr = hfr_pkg::HFR_PS_RUN;
        end else if (s.pf_cnt >= 32'(PF_CYCLES - 1)) begin
          next_s.pwr = hfr_pkg::HFR_PS_DOWN;
        end else begin
          next_s.pf_cnt = s.pf_cnt + 32'h1;
        end
      end
      hfr_pkg::HFR_PS_DOWN: begin
        if (supply_ok_i) begin
          next_s.pwr = hfr_pkg::HFR_PS_RUN;
          if ((startup_autotune_i || auto_rise_i) && eff == hfr_pkg::HFR_HOT_ONE) begin
            eff = hfr_pkg::HFR_HOT_TWO;
          end
          next_s.restart_valid = 1'b1;
          ev[`HFR_ST_RESTART] = 1'b1;
          next_s.saved_auto = was_auto_i;
          next_s.pend_restore = 1'b0;
          case (eff)
            hfr_pkg::HFR_HOT_ONE: begin
              next_s.restart_auto = was_auto_i;
              next_s.restart_run = was_run_i;
              next_s.out_src = hfr_pkg::HFR_OUT_HOLD;
            end
            hfr_pkg::HFR_HOT_TWO: begin
              next_s.restart_auto = was_auto_i;
              next_s.restart_run = was_run_i;
              if (was_auto_i) begin
                next_s.out_src = hfr_pkg::HFR_OUT_COMPUTE;
              end else if (position_control_i && !feedback_resistance_input_i) begin
                next_s.out_src = hfr_pkg::HFR_OUT_NONE;
              end else begin
                next_s.out_src = hfr_pkg::HFR_OUT_LOW_LIMIT;
              end
            end
            hfr_pkg::HFR_COLD: begin
              next_s.restart_auto = 1'b0;
              next_s.restart_run = was_run_i;
              if (position_control_i && !feedback_resistance_input_i) begin
                next_s.out_src = hfr_pkg::HFR_OUT_NONE;
              end else begin
                next_s.out_src = hfr_pkg::HFR_OUT_LOW_LIMIT;
              end
            end
            hfr_pkg::HFR_STOP: begin
              next_s.restart_auto = was_auto_i;
              next_s.restart_run = 1'b0;
              next_s.pend_restore = 1'b1;
              if (position_control_i && !feedback_resistance_input_i) begin
                next_s.out_src = hfr_pkg::HFR_OUT_VALVE;
              end else begin
                next_s.out_src = hfr_pkg::HFR_OUT_STOP_VALUE;
              end
            end
            default: begin
              next_s.out_src = hfr_pkg::HFR_OUT_HOLD;
            end
          endcase
        end
      end
      default: begin
        next_s.pwr = hfr_pkg::HFR_PS_RUN;
      end
    endcase
    // leaving stop restores the mode saved at the failure
    if (s.pend_restore && stop_to_run_i && s.pwr == hfr_pkg::HFR_PS_RUN) begin
      next_s.pend_restore = 1'b0;
      next_s.restart_run = 1'b1;
      next_s.restart_auto = s.saved_auto;
      next_s.out_src = s.saved_auto ? hfr_pkg::HFR_OUT_COMPUTE : hfr_pkg::HFR_OUT_HOLD;
    end
    // sticky status, write one clears, set wins
    if (wr_i && addr_i == `HFR_ADDR_STATUS) begin
      next_s.status = (s.status & ~wdata_i[`HFR_ST_NBITS-1:0]) | ev;
    end else begin
      next_s.status = s.status | ev;
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.sel <= `HFR_SEL_RESET;
      s.typ <= `HFR_TYPE_RESET;
      s.delay <= DELAY_W'(`HFR_DELAY_RESET);
      s.restart <= hfr_pkg::hfr_restart_t'(`HFR_RESTART_RESET);
      s.pwr <= hfr_pkg::HFR_PS_RUN;
      s.out_src <= hfr_pkg::HFR_OUT_HOLD;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = s.rdata;
  assign heater_fault_alarm_two_o = s.hfa;
  assign restart_valid_o = s.restart_valid;
  assign restart_auto_o = s.restart_auto;
  assign restart_run_o = s.restart_run;
  assign out_src_o = s.out_src;
  assign irq_o = s.irq;

endmodule // hfr_top

// *** verif/hfr_plant.sv ***
// Purpose: plant model of supply, load outputs and sensor two current
// Assumes: single clock, levels change just after a rising edge
// Notes: outage length is given in clock cycles
module hfr_plant #(
  parameter int CUR_W = 12
) (
  // clock
  input wire logic clk_i,
  // plant levels
  output logic supply_ok_o,
  output logic [CUR_W-1:0] current_o,
  output logic first_on_o,
  output logic second_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // both loads energized, supply present, no current yet
  initial begin
    supply_ok_o = 1'b1;
    current_o = '0;
    first_on_o = 1'b1;
    second_on_o = 1'b1;
  end
  // supply drops for n cycles, then returns
  task automatic outage(input int n);
    @(posedge clk_i);
    supply_ok_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    supply_ok_o <= 1'b1;
  endtask
  // new sensor reading, applied on an edge
  task automatic set_current(input logic [CUR_W-1:0] v);
    @(posedge clk_i);
    current_o <= v;
  endtask
endmodule // hfr_plant

// *** verif/hfr_assertions.sv ***
// Purpose: port assertions for the heater alarm two and restart block
// Assumes: selector and restart mode shadowed from register writes
// Notes: bound to hfr_top
`include "hfr_defs.svh"
module hfr_chk #(
  parameter int PF_CYCLES = 8
) (
  // clock, reset, register writes
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // supply and run conditions
  input wire logic supply_ok_i,
  input wire logic was_auto_i,
  input wire logic was_run_i,
  input wire logic feedback_resistance_input_i,
  input wire logic position_control_i,
  input wire logic startup_autotune_i,
  input wire logic auto_rise_i,
  input wire logic stop_to_run_i,
  // results
  input wire logic [1:0] heater_fault_alarm_two_o,
  input wire logic restart_valid_o,
  input wire logic restart_auto_o,
  input wire logic restart_run_o,
  input wire logic [2:0] out_src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sel;
  logic [1:0] mode;
  logic stop_seen;
  logic saved_auto;
  int low_cnt;
  logic no_fbr;
  logic [1:0] eff;
  // motorless position control and effective restart mode
  assign no_fbr = position_control_i & ~feedback_resistance_input_i;
  assign eff = (mode == hfr_pkg::HFR_HOT_ONE && (startup_autotune_i || auto_rise_i)) ? hfr_pkg::HFR_HOT_TWO : mode;
  // shadow config, outage length and stop start memory
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel <= 3'h0;
      mode <= 2'h0;
      stop_seen <= 1'b0;
      saved_auto <= 1'b0;
      low_cnt <= 0;
    end else begin
      if (wr_i && addr_i == `HFR_ADDR_CTRL) sel <= wdata_i[2:0];
      if (wr_i && addr_i == `HFR_ADDR_RESTART) mode <= wdata_i[1:0];
      if (restart_valid_o) stop_seen <= (eff == hfr_pkg::HFR_STOP);
      else if (stop_to_run_i) stop_seen <= 1'b0;
      if (restart_valid_o) saved_auto <= was_auto_i;
      if (supply_ok_i) low_cnt <= 0;
      else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence short_dip;
    $rose(supply_ok_i) && low_cnt < PF_CYCLES - 1;
  endsequence
  sequence long_outage;
    $rose(supply_ok_i) && low_cnt > PF_CYCLES + 1;
  endsequence
  a_pulse_single: assert property (restart_valid_o |=> !restart_valid_o)
    else $error("restart pulse longer than one cycle");
  a_dip_ignored: assert property (short_dip |-> !restart_valid_o [*3])
    else $error("restart after a short supply dip");
  a_long_restart: assert property (long_outage |-> ##[1:2] restart_valid_o)
    else $error("no restart after a long outage");
  a_hot_one: assert property (restart_valid_o && eff == hfr_pkg::HFR_HOT_ONE |->
    out_src_o == hfr_pkg::HFR_OUT_HOLD && restart_auto_o == was_auto_i && restart_run_o == was_run_i)
    else $error("hot start one result wrong");
  a_hot_two: assert property (restart_valid_o && eff == hfr_pkg::HFR_HOT_TWO |->
    restart_auto_o == was_auto_i && out_src_o == (was_auto_i ? hfr_pkg::HFR_OUT_COMPUTE :
    no_fbr ? hfr_pkg::HFR_OUT_NONE : hfr_pkg::HFR_OUT_LOW_LIMIT))
    else $error("hot start two result wrong");
  a_cold_manual: assert property (restart_valid_o && eff == hfr_pkg::HFR_COLD |-> !restart_auto_o &&
    out_src_o == (no_fbr ? hfr_pkg::HFR_OUT_NONE : hfr_pkg::HFR_OUT_LOW_LIMIT))
    else $error("cold start result wrong");
  a_stop_state: assert property (restart_valid_o && eff == hfr_pkg::HFR_STOP |-> !restart_run_o &&
    out_src_o == (no_fbr ? hfr_pkg::HFR_OUT_VALVE : hfr_pkg::HFR_OUT_STOP_VALUE))
    else $error("stop start result wrong");
  a_stop_restore: assert property (stop_seen && stop_to_run_i |=>
    restart_run_o && restart_auto_o == saved_auto)
    else $error("mode not restored on stop to run");
  a_alarm_off: assert property ((sel == 3'h0 || sel > 3'h2) [*4] |-> heater_fault_alarm_two_o == 2'h0)
    else $error("alarm raised while switched off");
  a_route_first: assert property ((sel == 3'h1) [*4] |-> !heater_fault_alarm_two_o[1])
    else $error("alarm on wrong output");
  a_route_second: assert property ((sel == 3'h2) [*4] |-> !heater_fault_alarm_two_o[0])
    else $error("alarm on wrong output");
endmodule // hfr_chk

bind hfr_top hfr_chk #(.PF_CYCLES(PF_CYCLES)) hfr_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .supply_ok_i(supply_ok_i), .was_auto_i(was_auto_i),
  .was_run_i(was_run_i), .feedback_resistance_input_i(feedback_resistance_input_i),
  .position_control_i(position_control_i), .startup_autotune_i(startup_autotune_i),
  .auto_rise_i(auto_rise_i), .stop_to_run_i(stop_to_run_i), .heater_fault_alarm_two_o(heater_fault_alarm_two_o),
  .restart_valid_o(restart_valid_o), .restart_auto_o(restart_auto_o), .restart_run_o(restart_run_o),
  .out_src_o(out_src_o));

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the heater alarm two and restart block
// Assumes: sample every 4 cycles, long outage above 8 cycles
// Notes: plant model drives supply, loads and sensor current
`include "hfr_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  localparam int PF = 8;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0;
  logic [11:0] brk = 12'h064, melt = 12'hFA0, mo = 12'h3E8;
  logic was_auto = 1'b0, was_run = 1'b1, feedback_resistance_input = 1'b0, pos = 1'b0, tune = 1'b0, rise = 1'b0, s2r = 1'b0;
  wire logic [31:0] rdata_o;
  wire logic [11:0] cur;
  wire logic f_on, s_on, sok, rv, ra, rr, irq;
  wire logic [1:0] hfa;
  wire logic [2:0] src;
  int bad_count = 0;
  int n_compared = 0;
  // design and plant
  hfr_top #(.SAMPLE_CYCLES(SC), .PF_CYCLES(PF)) hfr_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .current_i(cur),
    .break_limit_i(brk), .melt_limit_i(melt), .manipulated_output_i(mo), .first_output_on_i(f_on),
    .second_output_on_i(s_on), .supply_ok_i(sok), .was_auto_i(was_auto), .was_run_i(was_run),
    .feedback_resistance_input_i(feedback_resistance_input), .position_control_i(pos), .startup_autotune_i(tune),
    .auto_rise_i(rise), .stop_to_run_i(s2r), .heater_fault_alarm_two_o(hfa), .restart_valid_o(rv),
    .restart_auto_o(ra), .restart_run_o(rr), .out_src_o(src), .irq_o(irq));
  hfr_plant hfr_plant_inst (.clk_i(clk_i), .supply_ok_o(sok), .current_o(cur), .first_on_o(f_on),
    .second_on_o(s_on));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask
  // alarm must rise within the sample window of its count, on the routed output
  task automatic alarm_case(input logic [2:0] sel, input logic typ, input logic [7:0] dly, input logic [1:0] exp);
    int n;
    int k;
    k = (dly == 8'h00) ? 1 : int'(dly);
    wr(`HFR_ADDR_DELAY, {24'h0, dly});
    wr(`HFR_ADDR_CTRL, {27'h0, typ, 1'b0, sel});
    hfr_plant_inst.set_current(12'h000);
    n = 0;
    while (hfa === 2'h0 && n < (k + 2) * SC + 4) begin
      tick();
      n++;
    end
    chk("alarm output", {30'h0, exp}, {30'h0, hfa});
    if (exp != 2'h0) chk("alarm delay", 32'h1, {31'h0, n >= (k - 1) * SC && n <= k * SC + 4});
    hfr_plant_inst.set_current(12'h3E8);
    repeat (2 * SC + 4) tick();
    chk("alarm cleared", 32'h0, {30'h0, hfa});
  endtask
  // long outage, then check the restart decision
  task automatic restart_case(input logic [1:0] m, input logic a, input logic nf, input logic [1:0] t,
                              input logic [2:0] es, input logic ea);
    int n;
    wr(`HFR_ADDR_RESTART, {30'h0, m});
    @(posedge clk_i);
    was_auto <= a;
    pos <= nf | m[0];
    feedback_resistance_input <= ~nf;
    tune <= t[0];
    rise <= t[1];
    hfr_plant_inst.outage(2 * PF);
    n = 0;
    while (rv !== 1'b1 && n < 12) begin
      tick();
      n++;
    end
    chk("restart pulse", 32'h1, {31'h0, rv});
    chk("output source", {29'h0, es}, {29'h0, src});
    if (m != 2'h3) chk("restart auto", {31'h0, ea}, {31'h0, ra});
    if (m == 2'h0 || m == 2'h3) chk("restart run", {31'h0, m == 2'h0}, {31'h0, rr});
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog on a hung run
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  // main sequence
  initial begin
    int n;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk("ctrl reset", `HFR_ADDR_CTRL, 32'h0);
    rd_chk("delay reset", `HFR_ADDR_DELAY, 32'h5);
    rd_chk("restart reset", `HFR_ADDR_RESTART, 32'h0);
    rd_chk("status reset", `HFR_ADDR_STATUS, 32'h0);
    wr(`HFR_ADDR_CTRL, 32'h12);
    rd_chk("ctrl write", `HFR_ADDR_CTRL, 32'h12);
    wr(`HFR_ADDR_DELAY, 32'hFF);
    rd_chk("delay max", `HFR_ADDR_DELAY, 32'hFF);
    wr(8'h20, 32'hFF);
    rd_chk("unmapped", 8'h20, 32'h0);
    $display("test registers done");
    hfr_plant_inst.set_current(12'h3E8);
    alarm_case(3'h1, 1'b0, 8'h03, 2'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("alarm status", `HFR_ADDR_STATUS, 32'h1);
    wr(`HFR_ADDR_MASK, 32'h3);
    tick();
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(`HFR_ADDR_STATUS, 32'h1);
    tick();
    chk("irq cleared", 32'h0, {31'h0, irq});
    alarm_case(3'h2, 1'b0, 8'h00, 2'h2);
    alarm_case(3'h2, 1'b1, 8'h02, 2'h2);
    alarm_case(3'h1, 1'b1, 8'h05, 2'h1);
    alarm_case(3'h0, 1'b0, 8'h01, 2'h0);
    alarm_case(3'h3, 1'b0, 8'h01, 2'h0);
    wr(`HFR_ADDR_STATUS, 32'h3);
    $display("test alarm done");
    hfr_plant_inst.outage(PF / 2);
    n = 0;
    repeat (12) begin
      tick();
      if (rv === 1'b1) n++;
    end
    chk("short dip ignored", 32'h0, n);
    restart_case(2'h0, 1'b1, 1'b0, 2'h0, hfr_pkg::HFR_OUT_HOLD, 1'b1);
    rd_chk("restart status", `HFR_ADDR_STATUS, 32'h2);
    restart_case(2'h0, 1'b1, 1'b0, 2'h1, hfr_pkg::HFR_OUT_COMPUTE, 1'b1);
    restart_case(2'h0, 1'b0, 1'b1, 2'h2, hfr_pkg::HFR_OUT_NONE, 1'b0);
    restart_case(2'h1, 1'b0, 1'b0, 2'h0, hfr_pkg::HFR_OUT_LOW_LIMIT, 1'b0);
    restart_case(2'h1, 1'b1, 1'b1, 2'h0, hfr_pkg::HFR_OUT_COMPUTE, 1'b1);
    restart_case(2'h2, 1'b1, 1'b0, 2'h0, hfr_pkg::HFR_OUT_LOW_LIMIT, 1'b0);
    restart_case(2'h2, 1'b1, 1'b1, 2'h0, hfr_pkg::HFR_OUT_NONE, 1'b0);
    restart_case(2'h3, 1'b1, 1'b0, 2'h0, hfr_pkg::HFR_OUT_STOP_VALUE, 1'b0);
    restart_case(2'h3, 1'b0, 1'b1, 2'h0, hfr_pkg::HFR_OUT_VALVE, 1'b0);
    @(posedge clk_i);
    was_auto <= 1'b1;
    s2r <= 1'b1;
    @(posedge clk_i);
    s2r <= 1'b0;
    #1;
    chk("run after stop", 32'h1, {31'h0, rr});
    chk("auto after stop", 32'h0, {31'h0, ra});
    $display("test restart done");
    final_report();
  end
endmodule // testbench
